// ---- rtl/capsm_pkg.sv ----
package capsm_pkg;
  // register byte offsets (sense_control_0 has no printed offset)
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_GATE    = 8'h04;
  localparam logic [7:0] ADDR_COUNT   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  // sense_control_0 fields
  localparam int CTRL0_EN_BIT  = 7;
  localparam int CTRL0_RNG_LSB = 2;
  localparam int CTRL0_DIR_BIT = 1;
  localparam int CTRL0_XCS_BIT = 0;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  // gate control fields
  localparam int GATE_SRC_LSB = 0;
  localparam int GATE_TM_BIT  = 2;
  localparam int GATE_EN_BIT  = 3;
  localparam int GATE_ON_BIT  = 4;
  localparam int GATE_CLR_BIT = 8;
  localparam logic [1:0] GATE_SRC_WATCHDOG = 2'h3;
  localparam logic [4:0] GATE_RESET   = 5'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : capsm_pkg

// ---- rtl/capsm_sync.sv ----
`timescale 1ns/100ps
// two-flop synchroniser plus rising-edge pulse from the synchronised level
module capsm_sync (
  input  wire logic aclk,     // core clock
  input  wire logic aresetn,  // sync reset, active low
  input  wire logic async_in, // pin level
  output logic      level,    // synchronised level
  output logic      rise      // one-cycle pulse on rising edge
);
  logic meta_q;
  logic lvl_q;
  logic old_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      lvl_q  <= 1'b0;
      old_q  <= 1'b0;
    end else begin
      meta_q <= async_in;
      lvl_q  <= meta_q;
      old_q  <= lvl_q;
    end
  end

  assign level = lvl_q;
  assign rise  = lvl_q & ~old_q;
endmodule : capsm_sync

// ---- rtl/capsm_top.sv ----
`timescale 1ns/100ps
module capsm_top
  import capsm_pkg::*;
#(
  parameter int CNT_W = 16,  // gated counter width
  parameter int SCNT_W = 8   // small counter width
) (
  input  wire logic        aclk,          // 40 MHz core clock
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read valid
  input  wire logic        s_axi_rready,  // read ready
  input  wire logic        sense_osc_in,  // oscillator output from sense_input_pin
  input  wire logic        ext_clk_pin,   // small counter external clock pin
  input  wire logic        watchdog_overflow, // watchdog_timer overflow level/pulse
  input  wire logic        cpu_sleep,     // core asleep
  output logic             osc_enable,    // oscillator analog enable
  output logic [1:0]       osc_range,     // oscillator current range
  output logic             small_clk_out  // clock routed to small_counter
);
  typedef enum logic [1:0] {GT_IDLE, GT_OPEN, GT_DONE} capsm_gate_e;

  logic [7:0]       ctrl0_q;
  logic [4:0]       gate_q;
  logic [CNT_W-1:0] count_q;
  logic [SCNT_W-1:0] scount_q;
  capsm_gate_e      gst_q;
  logic             osc_lvl, osc_rise, ext_lvl, watchdog_lvl, watchdog_rise;
  logic             wd_gate_ev;
  logic             aw_hold_q, w_hold_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             wr_go, clr_pulse, gate_open, cnt_en, sens_en;

  capsm_sync u_osc (.aclk(aclk), .aresetn(aresetn), .async_in(sense_osc_in),
                    .level(osc_lvl), .rise(osc_rise));
  capsm_sync u_ext (.aclk(aclk), .aresetn(aresetn), .async_in(ext_clk_pin),
                    .level(ext_lvl), .rise());
  capsm_sync u_watchdog (.aclk(aclk), .aresetn(aresetn), .async_in(watchdog_overflow),
                         .level(watchdog_lvl), .rise(watchdog_rise));

  // axi write: take address and data in either order, answer after both
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == ADDR_CTRL0 || awaddr_q == ADDR_GATE) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register; direction bit is live state, never stored from the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= CTRL0_RESET;
    end else if (wr_go && awaddr_q == ADDR_CTRL0 && wstrb_q[0]) begin
      ctrl0_q[CTRL0_EN_BIT]                  <= wdata_q[CTRL0_EN_BIT];
      ctrl0_q[CTRL0_RNG_LSB+1:CTRL0_RNG_LSB] <= wdata_q[CTRL0_RNG_LSB+1:CTRL0_RNG_LSB];
      ctrl0_q[CTRL0_XCS_BIT]                 <= wdata_q[CTRL0_XCS_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_q <= GATE_RESET;
    end else if (wr_go && awaddr_q == ADDR_GATE && wstrb_q[0]) begin
      gate_q <= wdata_q[4:0];
    end
  end
  assign clr_pulse = wr_go && awaddr_q == ADDR_GATE && wstrb_q[1] && wdata_q[GATE_CLR_BIT];

  assign sens_en = ctrl0_q[CTRL0_EN_BIT];
  // oscillator held on, independent of sleep
  assign osc_enable = sens_en;
  assign osc_range  = sens_en ? ctrl0_q[CTRL0_RNG_LSB+1:CTRL0_RNG_LSB] : 2'h0;

  assign wd_gate_ev = watchdog_rise &&
                      gate_q[GATE_SRC_LSB+1:GATE_SRC_LSB] == GATE_SRC_WATCHDOG;

  // gate toggle state; a source other than watchdog leaves the gate closed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gst_q <= GT_IDLE;
    end else if (!gate_q[GATE_EN_BIT] || !gate_q[GATE_TM_BIT]) begin
      gst_q <= GT_IDLE;
    end else if (clr_pulse) begin
      // an overflow landing on the clear still opens the window: the set wins
      gst_q <= wd_gate_ev ? GT_OPEN : GT_IDLE;
    end else if (wd_gate_ev) begin
      unique case (gst_q)
        GT_IDLE: gst_q <= GT_OPEN;
        GT_OPEN: gst_q <= GT_DONE;
        GT_DONE: gst_q <= GT_DONE;
        default: gst_q <= GT_IDLE;
      endcase
    end
  end

  // window follows the actual overflow timing, however late
  always_comb begin
    if (!gate_q[GATE_EN_BIT]) begin
      gate_open = 1'b1;
    end else if (gate_q[GATE_TM_BIT]) begin
      gate_open = (gst_q == GT_OPEN);
    end else begin
      gate_open = (gate_q[GATE_SRC_LSB+1:GATE_SRC_LSB] == GATE_SRC_WATCHDOG) && watchdog_lvl;
    end
  end
  assign cnt_en = sens_en && gate_q[GATE_ON_BIT] && gate_open && osc_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (clr_pulse) begin
      count_q <= '0;
    end else if (cnt_en) begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scount_q <= '0;
    end else if (!cpu_sleep && sens_en && ctrl0_q[CTRL0_XCS_BIT] && osc_rise) begin
      scount_q <= scount_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      small_clk_out <= 1'b0;
    end else begin
      small_clk_out <= ctrl0_q[CTRL0_XCS_BIT] ? (osc_lvl && sens_en) : ext_lvl;
    end
  end

  // axi read, one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL0:  s_axi_rdata <= {24'h0, ctrl0_q[7], 3'h0, ctrl0_q[3:2],
                                     osc_lvl && sens_en, ctrl0_q[0]};
        ADDR_GATE:   s_axi_rdata <= {27'h0, gate_q};
        ADDR_COUNT:  s_axi_rdata <= {{(32-CNT_W){1'b0}}, count_q};
        ADDR_STATUS: s_axi_rdata <= {22'h0, gst_q, scount_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_off_no_range;
    @(posedge aclk) disable iff (!aresetn) !osc_enable |-> osc_range == 2'h0;
  endproperty
  a_off_no_range: assert property (p_off_no_range) else $error("range on while off");
  property p_done_holds;
    @(posedge aclk) disable iff (!aresetn)
      (gst_q == GT_DONE && gate_q[GATE_EN_BIT] && gate_q[GATE_TM_BIT] && !clr_pulse)
      |=> $stable(count_q);
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("count moved after stop");
  property p_toggle_open;
    @(posedge aclk) disable iff (!aresetn)
      (gst_q == GT_IDLE && watchdog_rise && gate_q == 5'h1f && !clr_pulse) |=> gst_q == GT_OPEN;
  endproperty
  a_toggle_open: assert property (p_toggle_open) else $error("gate did not open");
  property p_sleep_small;
    @(posedge aclk) disable iff (!aresetn) cpu_sleep |=> $stable(scount_q);
  endproperty
  a_sleep_small: assert property (p_sleep_small) else $error("small counter ran asleep");
  sequence s_open_stop;
    gst_q == GT_OPEN && watchdog_rise && gate_q == 5'h1f && !clr_pulse;
  endsequence
  property p_toggle_close;
    @(posedge aclk) disable iff (!aresetn) s_open_stop |=> gst_q == GT_DONE;
  endproperty
  a_toggle_close: assert property (p_toggle_close) else $error("gate did not close");
  property p_off_no_count;
    @(posedge aclk) disable iff (!aresetn) (!sens_en && !clr_pulse) |=> $stable(count_q);
  endproperty
  a_off_no_count: assert property (p_off_no_count) else $error("count moved while off");
  property p_unimpl_zero;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CTRL0)
      |=> s_axi_rdata[6:4] == 3'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused control bits set");
endmodule : capsm_top

// ---- tb/capsm_pad.sv ----
`timescale 1ns/100ps
// touch pad with its relaxation oscillator; half_ns sets the load
module capsm_pad (
  input  wire logic       osc_enable, // oscillator powered
  input  wire logic [9:0] half_ns,    // half period in ns
  input  wire logic       hold_en,    // freeze the pin level
  input  wire logic       hold_val,   // level while frozen
  output logic            sense_osc   // oscillator level
);
  // runs whenever enabled and hold_en is low
  // the bench starts with hold_en high, so the first pass gives the level a value
  // sleep is not an input on purpose; a larger half_ns models the loaded pad
  always begin
    if (hold_en) sense_osc = hold_val;
    else if (osc_enable) sense_osc = ~sense_osc;
    else sense_osc = 1'b0;
    #(half_ns);
  end
endmodule : capsm_pad

// ---- tb/test_capacitive_sense_measurement.sv ----
`timescale 1ns/100ps
module test_capacitive_sense_measurement;
  import capsm_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic ext_clk_pin = 1'b0, watchdog_overflow = 1'b0, cpu_sleep = 1'b0;
  logic hold_en = 1'b1, hold_val = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, rd2;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [9:0] half_ns = 10'd125;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sense_osc_in, osc_enable, small_clk_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, osc_range, rs, wrs;
  int error_cnt = 0, n_compared = 0, cyc = 0, c0, c1;
  always #12.5 aclk = ~aclk;
  capsm_top dut (.*);
  capsm_pad pad (.osc_enable(osc_enable), .half_ns(half_ns), .hold_en(hold_en),
                 .hold_val(hold_val), .sense_osc(sense_osc_in));
  task automatic print_verdict();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wrs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // idle edge: a following call must not drive bready twice in one step
    @(posedge aclk);
  endtask : wr
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // idle edge: a following call must not drive rready twice in one step
    @(posedge aclk);
  endtask : rdw
  // gate window of 400 cycles (10000 ns); expected count 5000/half_ns
  task automatic measure(input logic [9:0] h, output int c);
    half_ns = h;
    wr(ADDR_GATE, 32'h1f, 4'h1);
    wr(ADDR_CTRL0, 32'h8c, 4'h1);
    wr(ADDR_GATE, 32'h11f, 4'h3);
    cpu_sleep <= 1'b1;
    repeat (2) begin
      watchdog_overflow <= 1'b1;
      repeat (4) @(posedge aclk);
      watchdog_overflow <= 1'b0;
      repeat (396) @(posedge aclk);
    end
    cpu_sleep <= 1'b0;
    rdw(ADDR_STATUS, rd, rs); chk({30'h0, rd[9:8]}, 32'h2);
    rdw(ADDR_COUNT, rd, rs); chk_rng(rd, 5000 / h - 2, 5000 / h + 2);
    c = rd;
    // count is read-only: the write is refused and must not disturb it
    wr(ADDR_COUNT, 32'h0000_ffff, 4'h3);
    chk({30'h0, wrs}, {30'h0, RESP_SLVERR});
    repeat (60) @(posedge aclk);
    rdw(ADDR_COUNT, rd2, rs); chk(rd2, rd);
  endtask : measure
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdw(ADDR_CTRL0, rd, rs); chk(rd, 32'h0);
    rdw(ADDR_GATE, rd, rs); chk(rd, 32'h0);
    wr(ADDR_CTRL0, 32'hff, 4'h1);
    chk({30'h0, wrs}, {30'h0, RESP_OKAY});
    rdw(ADDR_CTRL0, rd, rs); chk(rd, 32'h8d);
    chk({29'h0, osc_enable, osc_range}, 32'h7);
    wr(ADDR_CTRL0, 32'h0c, 4'h1);
    chk({29'h0, osc_enable, osc_range}, 32'h0);
    // pad frozen high, then low: status bit follows the pin
    wr(ADDR_CTRL0, 32'h8d, 4'h1);
    hold_val <= 1'b1;
    repeat (6) @(posedge aclk);
    rdw(ADDR_CTRL0, rd, rs); chk(rd, 32'h8f);
    chk({31'h0, small_clk_out}, 32'h1);
    hold_val <= 1'b0;
    repeat (6) @(posedge aclk);
    rdw(ADDR_CTRL0, rd, rs); chk(rd, 32'h8d);
    chk({31'h0, small_clk_out}, 32'h0);
    wr(ADDR_CTRL0, 32'h80, 4'h1);
    ext_clk_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({31'h0, small_clk_out}, 32'h1);
    // small counter on the oscillator must freeze while asleep
    hold_en <= 1'b0;
    wr(ADDR_CTRL0, 32'h8d, 4'h1);
    cpu_sleep <= 1'b1;
    rdw(ADDR_STATUS, rd, rs);
    repeat (100) @(posedge aclk);
    rdw(ADDR_STATUS, rd2, rs); chk(rd2[7:0], rd[7:0]);
    cpu_sleep <= 1'b0;
    repeat (100) @(posedge aclk);
    rdw(ADDR_STATUS, rd2, rs); chk(rd2[7:0] !== rd[7:0], 32'h1);
    rdw(8'h10, rd, rs); chk({rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
    measure(10'd125, c0);
    measure(10'd200, c1);
    // threshold midway must separate the two results
    chk((c1 < (c0 + c1) / 2) && ((c0 + c1) / 2 < c0), 32'h1);
    print_verdict();
  end
endmodule : test_capacitive_sense_measurement
